// *** design/hif_defs.svh ***
// Purpose: offsets, field positions and reset values of the hub
//          interrupt and forwarding status block
// Assumes: byte-wide registers on a plain strobe port
// Notes: included by bare name by the top design file only
`ifndef HIF_DEFS_SVH
`define HIF_DEFS_SVH

`define HIF_OFS_FORWARD_STATE 8'h22
`define HIF_OFS_IRQ_CONTROL 8'h23
`define HIF_OFS_IRQ_PENDING 8'h24
`define HIF_OFS_EVT_STATUS 8'h30
`define HIF_OFS_EVT_MASK 8'h31

`define HIF_RST_FORWARD_STATE 8'h00
`define HIF_RST_IRQ_CONTROL 8'h00
`define HIF_RST_IRQ_PENDING 8'h00
`define HIF_RST_EVT 3'h0

// forward_state fields
`define HIF_BIT_VIDEO_ALIGNED 0
`define HIF_BIT_ALIGN_LOST 2

// irq_control and irq_pending fields
`define HIF_BIT_RX0 0
`define HIF_BIT_TX 4
`define HIF_BIT_CTL_SPARE 5
`define HIF_BIT_GLOBAL 7

// local event status fields
`define HIF_EVT_ALIGN_LOST 0
`define HIF_EVT_MODE_CLASH 1
`define HIF_EVT_ALIGN_GAIN 2

`endif

// *** design/hif_pkg.sv ***
// Purpose: shared types of the hub interrupt and forwarding status block
// Assumes: nothing
// Notes: numbers live in hif_defs.svh
package hif_pkg;

   typedef logic [7:0] hif_byte_t;

   // alignment monitor progress
   typedef enum logic [1:0]
   {
      HIF_MON_OFF,
      HIF_MON_WAIT_FRAME,
      HIF_MON_ARMED
   } hif_mon_state_t;

endpackage

// *** design/hif_sticky.sv ***
// Purpose: vector of sticky flags, set by events, cleared by pulses
// Assumes: set and clear pulses come from logic on clk_sys
// Notes: a set in the same cycle as a clear wins
`timescale 1ns/100ps
module hif_sticky
   import hif_pkg::*;
#(
   parameter int WIDTH = 5
)
(
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic [WIDTH-1:0] set_pulse,
   input wire logic [WIDTH-1:0] clr_pulse,
   output logic [WIDTH-1:0] flag
);

   logic [WIDTH-1:0] flag_ff;
   logic [WIDTH-1:0] nxt_flag;

   if (WIDTH < 1)
   begin : g_chk
      $error("hif_sticky: WIDTH must be at least 1");
   end

   // set wins so no event is lost on a clear
   assign nxt_flag = set_pulse | (flag_ff & ~clr_pulse);
   assign flag = flag_ff;

   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
         flag_ff <= '0;
      else
         flag_ff <= nxt_flag;
   end

endmodule

// *** design/hif_align_mon.sv ***
// Purpose: tracks aligned forwarding, raises the alignment-lost flag
// Assumes: engine signals are on clk_sys, mode level from config logic
// Notes: a loss only counts after one aligned frame went out
`timescale 1ns/100ps
module hif_align_mon
   import hif_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic mode_on,
   input wire logic engine_aligned,
   input wire logic frame_sent,
   input wire logic loss_seen,
   input wire logic read_clear,
   output logic aligned,
   output logic lost,
   output logic lost_evt
);

   hif_mon_state_t state_ff;
   hif_mon_state_t nxt_state;
   logic aligned_ff;
   logic lost_ff;
   logic lost_evt_ff;
   logic loss_counts;

   assign loss_counts = (state_ff == HIF_MON_ARMED) && mode_on && loss_seen;

   always_comb
   begin
      nxt_state = state_ff;
      unique case (state_ff)
         HIF_MON_OFF:
            if (mode_on)
               nxt_state = HIF_MON_WAIT_FRAME;
         HIF_MON_WAIT_FRAME:
            if (!mode_on)
               nxt_state = HIF_MON_OFF;
            else if (frame_sent)
               nxt_state = HIF_MON_ARMED;
         HIF_MON_ARMED:
            if (!mode_on)
               nxt_state = HIF_MON_OFF;
            else if (loss_seen)
               nxt_state = HIF_MON_WAIT_FRAME; // rearm on next good frame
      endcase
   end

   assign aligned = aligned_ff;
   assign lost = lost_ff;
   assign lost_evt = lost_evt_ff;

   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         state_ff <= HIF_MON_OFF;
         aligned_ff <= 1'b0;
         lost_ff <= 1'b0;
         lost_evt_ff <= 1'b0;
      end
      else
      begin
         state_ff <= nxt_state;
         aligned_ff <= mode_on & engine_aligned;
         lost_ff <= loss_counts | (lost_ff & ~read_clear);
         lost_evt_ff <= loss_counts;
      end
   end

endmodule

// *** design/hif_top.sv ***
// Purpose: forwarding status and interrupt aggregation for a four-port
//          receive hub with one transmit port
// Assumes: all inputs come from logic on clk_sys; register port is a
//          plain strobe port with read data one cycle after the strobe
// Notes: local events use a separate w1c status and mask pair
//
// What this block does
// - in aligned mode, set lost flag on loss, only after one aligned frame
// - reading forward_state clears the lost flag; one means failure
// - aligned bit follows engine alignment, forced zero when mode is off
// - host_irq asserts only while the global enable bit is set
// - separate enables: transmit source bit 4, receive ports bits 3..0
// - global pending bit set when any enabled source is pending
// - global pending ignores the global enable so software can poll
// - transmit pending set by its event, cleared by its status read
// - receive pending set by port event, cleared by port status reads
// - all enables and status bits of the three registers reset to zero
//
// The strobed register port was decided locally.
`timescale 1ns/100ps
`include "hif_defs.svh"
module hif_top
   import hif_pkg::*;
#(
   parameter int ADDR_W = 8,
   parameter int RX_PORTS = 4
)
(
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic round_robin_forward_mode,
   input wire logic aligned_forward_mode,
   input wire logic fwd_engine_aligned,
   input wire logic fwd_frame_sent,
   input wire logic fwd_align_loss,
   input wire logic tx_port_event,
   input wire logic tx_port_event_status_rd,
   input wire logic [RX_PORTS-1:0] rx_port_event,
   input wire logic [RX_PORTS-1:0] rx_port_cause_rd,
   output logic host_irq,
   output logic evt_irq
);

   localparam int NSRC = RX_PORTS + 1;
   localparam int NEVT = 3;

   if (ADDR_W < 8)
   begin : g_chk_addr
      $error("hif_top: ADDR_W must hold an 8-bit offset");
   end
   if (RX_PORTS != 4)
   begin : g_chk_ports
      $error("hif_top: register layout serves exactly four receive ports");
   end

   // register state
   logic global_en_ff;
   logic ctl_spare_ff;
   logic [NSRC-1:0] src_en_ff;
   logic [NEVT-1:0] evt_mask_ff;
   logic [7:0] rdata_ff;
   logic host_irq_ff;
   logic evt_irq_ff;
   logic clash_ff;

   // decode
   wire logic [7:0] addr8;
   wire logic hit_fwd;
   wire logic hit_ctl;
   wire logic hit_pend;
   wire logic hit_evt;
   wire logic hit_mask;
   wire logic wr_ctl;
   wire logic wr_evt;
   wire logic wr_mask;
   wire logic rd_fwd;

   assign addr8 = reg_addr[7:0];
   assign hit_fwd = (addr8 == `HIF_OFS_FORWARD_STATE) && (reg_addr[ADDR_W-1:0]
      == ADDR_W'(`HIF_OFS_FORWARD_STATE));
   assign hit_ctl = reg_addr == ADDR_W'(`HIF_OFS_IRQ_CONTROL);
   assign hit_pend = reg_addr == ADDR_W'(`HIF_OFS_IRQ_PENDING);
   assign hit_evt = reg_addr == ADDR_W'(`HIF_OFS_EVT_STATUS);
   assign hit_mask = reg_addr == ADDR_W'(`HIF_OFS_EVT_MASK);
   assign wr_ctl = reg_wr & hit_ctl;
   assign wr_evt = reg_wr & hit_evt;
   assign wr_mask = reg_wr & hit_mask;
   assign rd_fwd = reg_rd & hit_fwd;

   // forwarding monitor
   wire logic video_aligned_flag;
   wire logic alignment_lost_flag;
   wire logic lost_evt;

   hif_align_mon u_mon
   (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .mode_on(aligned_forward_mode),
      .engine_aligned(fwd_engine_aligned),
      .frame_sent(fwd_frame_sent),
      .loss_seen(fwd_align_loss),
      .read_clear(rd_fwd),
      .aligned(video_aligned_flag),
      .lost(alignment_lost_flag),
      .lost_evt(lost_evt)
   );

   // per-source pending flags, receive ports low, transmit on top
   wire logic [NSRC-1:0] src_set;
   wire logic [NSRC-1:0] src_clr;
   wire logic [NSRC-1:0] src_pending;

   assign src_set = {tx_port_event, rx_port_event};
   assign src_clr = {tx_port_event_status_rd, rx_port_cause_rd};

   hif_sticky #(.WIDTH(NSRC)) u_src
   (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .set_pulse(src_set),
      .clr_pulse(src_clr),
      .flag(src_pending)
   );

   // named views of the sources
   wire logic tx_source_pending;
   wire logic rx0_source_pending;
   wire logic rx1_source_pending;
   wire logic rx2_source_pending;
   wire logic rx3_source_pending;
   wire logic tx_source_mask;
   wire logic rx0_source_mask;
   wire logic rx1_source_mask;
   wire logic rx2_source_mask;
   wire logic rx3_source_mask;

   assign tx_source_pending = src_pending[RX_PORTS];
   assign rx0_source_pending = src_pending[0];
   assign rx1_source_pending = src_pending[1];
   assign rx2_source_pending = src_pending[2];
   assign rx3_source_pending = src_pending[3];
   assign tx_source_mask = src_en_ff[RX_PORTS];
   assign rx0_source_mask = src_en_ff[0];
   assign rx1_source_mask = src_en_ff[1];
   assign rx2_source_mask = src_en_ff[2];
   assign rx3_source_mask = src_en_ff[3];

   // global pending never looks at the global enable
   wire logic [NSRC-1:0] src_live;
   wire logic global_pending;

   genvar gi;
   for (gi = 0; gi < NSRC; gi++)
   begin : g_src
      assign src_live[gi] = src_pending[gi] & src_en_ff[gi];
   end

   assign global_pending = |src_live;

   // local events: alignment lost, both forwarding modes on, alignment won
   logic aligned_q_ff;
   wire logic clash_now;
   wire logic clash_rise;
   wire logic gain_evt;
   wire logic [NEVT-1:0] evt_set;
   wire logic [NEVT-1:0] evt_clr;
   wire logic [NEVT-1:0] evt_status;

   // software should never run both modes; flag it rather than arbitrate
   assign clash_now = round_robin_forward_mode & aligned_forward_mode;
   assign clash_rise = clash_now & ~clash_ff;
   assign gain_evt = video_aligned_flag & ~aligned_q_ff;
   assign evt_set = {gain_evt, clash_rise, lost_evt};
   assign evt_clr = wr_evt ? reg_wdata[NEVT-1:0] : '0;

   hif_sticky #(.WIDTH(NEVT)) u_evt
   (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .set_pulse(evt_set),
      .clr_pulse(evt_clr),
      .flag(evt_status)
   );

   // register images
   wire logic [7:0] img_fwd;
   wire logic [7:0] img_ctl;
   wire logic [7:0] img_pend;
   wire logic [7:0] img_evt;
   wire logic [7:0] img_mask;
   wire logic [7:0] nxt_rdata;

   assign img_fwd = {5'h0, alignment_lost_flag, 1'b0, video_aligned_flag};
   assign img_ctl = {global_en_ff, 1'b0, ctl_spare_ff, src_en_ff};
   assign img_pend = {global_pending, 2'h0, src_pending};
   assign img_evt = {5'h0, evt_status};
   assign img_mask = {5'h0, evt_mask_ff};

   // unmapped offsets read zero
   assign nxt_rdata = !reg_rd ? 8'h00 :
      hit_fwd ? img_fwd :
      hit_ctl ? img_ctl :
      hit_pend ? img_pend :
      hit_evt ? img_evt :
      hit_mask ? img_mask : 8'h00;

   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         global_en_ff <= 1'(`HIF_RST_IRQ_CONTROL >> `HIF_BIT_GLOBAL);
         ctl_spare_ff <= 1'b0;
         src_en_ff <= '0;
      end
      else if (wr_ctl)
      begin
         global_en_ff <= reg_wdata[`HIF_BIT_GLOBAL];
         ctl_spare_ff <= reg_wdata[`HIF_BIT_CTL_SPARE];
         src_en_ff <= reg_wdata[`HIF_BIT_TX:`HIF_BIT_RX0];
      end
   end

   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
         evt_mask_ff <= `HIF_RST_EVT;
      else if (wr_mask)
         evt_mask_ff <= reg_wdata[NEVT-1:0];
   end

   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
         rdata_ff <= 8'h00;
      else
         rdata_ff <= nxt_rdata;
   end

   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         clash_ff <= 1'b0;
         aligned_q_ff <= 1'b0;
      end
      else
      begin
         clash_ff <= clash_now;
         aligned_q_ff <= video_aligned_flag;
      end
   end

   // pin is one flop behind the pending state
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         host_irq_ff <= 1'b0;
         evt_irq_ff <= 1'b0;
      end
      else
      begin
         host_irq_ff <= global_en_ff & global_pending;
         evt_irq_ff <= |(evt_status & evt_mask_ff);
      end
   end

   assign reg_rdata = rdata_ff;
   assign host_irq = host_irq_ff;
   assign evt_irq = evt_irq_ff;

endmodule

// *** verification/hif_checker_asserts.sv ***
// Purpose: port checker for hif_top
// Assumes: one clock domain, plain strobe register port
// Notes: irq_control and pending are rebuilt from the inputs
`timescale 1ns/100ps
module hif_checker
   import hif_pkg::*;
#(
   parameter int ADDR_W = 8,
   parameter int RX_PORTS = 4
)
(
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic round_robin_forward_mode,
   input wire logic aligned_forward_mode,
   input wire logic fwd_engine_aligned,
   input wire logic fwd_frame_sent,
   input wire logic fwd_align_loss,
   input wire logic tx_port_event,
   input wire logic tx_port_event_status_rd,
   input wire logic [RX_PORTS-1:0] rx_port_event,
   input wire logic [RX_PORTS-1:0] rx_port_cause_rd,
   input wire logic host_irq,
   input wire logic evt_irq
);
   logic [7:0] ctl_ff;
   logic [4:0] pend_ff;
   wire logic rd_fwd = reg_rd && reg_addr == ADDR_W'(8'h22);
   wire logic rd_ctl = reg_rd && reg_addr == ADDR_W'(8'h23);
   wire logic rd_pend = reg_rd && reg_addr == ADDR_W'(8'h24);
   wire logic wr_ctl = reg_wr && reg_addr == ADDR_W'(8'h23);
   wire logic gp = |(pend_ff & ctl_ff[4:0]);
   wire logic [7:0] pend_img = {gp, 2'h0, pend_ff};
   wire logic [7:0] nxt_ctl = wr_ctl ? (reg_wdata & 8'hbf) : ctl_ff;
   // a set in the same cycle as its clear wins
   wire logic [4:0] nxt_pend = (pend_ff
      & ~{tx_port_event_status_rd, rx_port_cause_rd})
      | {tx_port_event, rx_port_event};

   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         ctl_ff <= 8'h00;
         pend_ff <= 5'h00;
      end
      else
      begin
         ctl_ff <= nxt_ctl;
         pend_ff <= nxt_pend;
      end
   end

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rstn);

   irq_gate_a: assert property (
      !$past(ctl_ff[7]) |-> !host_irq) else $error("irq while disabled");
   irq_level_a: assert property (
      host_irq == $past(ctl_ff[7] && gp)) else $error("irq level wrong");
   tx_raise_a: assert property (
      tx_port_event && ctl_ff[7] && ctl_ff[4] && !reg_wr |-> ##2 host_irq)
      else $error("tx event gave no irq");
   rx_raise_a: assert property (
      |(rx_port_event & ctl_ff[3:0]) && ctl_ff[7] && !reg_wr |-> ##2
      host_irq) else $error("rx event gave no irq");
   pend_read_a: assert property (
      rd_pend |=> reg_rdata == $past(pend_img)) else $error("pending bad");
   ctl_read_a: assert property (
      rd_ctl |=> reg_rdata == $past(ctl_ff)) else $error("control bad");
   aligned_read_a: assert property (
      rd_fwd && $past(rstn) |=> reg_rdata[0] ==
      $past(aligned_forward_mode && fwd_engine_aligned, 2))
      else $error("aligned bit wrong");
   lost_clear_a: assert property (
      rd_fwd && !fwd_align_loss ##1 rd_fwd |=> !reg_rdata[2])
      else $error("lost flag not cleared by read");

   cover property (host_irq);
   cover property (rd_fwd ##1 reg_rdata[2]);
   cover property (|rx_port_event);
endmodule

bind hif_top hif_checker #(.ADDR_W(ADDR_W), .RX_PORTS(RX_PORTS)) u_chk (
   .clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata),
   .round_robin_forward_mode(round_robin_forward_mode),
   .aligned_forward_mode(aligned_forward_mode),
   .fwd_engine_aligned(fwd_engine_aligned),
   .fwd_frame_sent(fwd_frame_sent), .fwd_align_loss(fwd_align_loss),
   .tx_port_event(tx_port_event),
   .tx_port_event_status_rd(tx_port_event_status_rd),
   .rx_port_event(rx_port_event), .rx_port_cause_rd(rx_port_cause_rd),
   .host_irq(host_irq), .evt_irq(evt_irq));

// *** verification/hif_host_model.sv ***
// Purpose: host controller watching the hub interrupt line
// Assumes: level interrupt on the hub clock
// Notes: counts rising edges so the bench can match them
`timescale 1ns/100ps
module hif_host_model
(
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic host_irq,
   output int irq_edges
);
   logic seen_ff;
   always @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         seen_ff <= 1'h0;
         irq_edges <= 0;
      end
      else
      begin
         seen_ff <= host_irq;
         if (host_irq && !seen_ff)
            irq_edges <= irq_edges + 1;
      end
   end
endmodule

// *** verification/tb.sv ***
// Purpose: self-checking bench for hif_top
// Assumes: 250 MHz clock, reset held for 12 cycles
// Notes: a cycle model predicts every read and the interrupt line
`timescale 1ns/100ps
`define CHK(n, e, g) begin checked++; if ((e) !== (g)) begin \
   num_errors++; $display("[ERR] %s exp %0h got %0h", n, e, g); end end
module tb;
   logic clk_sys = 1'h0, rstn = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0;
   logic rr_mode = 1'h0, al_mode = 1'h0, eng = 1'h0;
   logic frame = 1'h0, loss = 1'h0, tx_ev = 1'h0, tx_rd = 1'h0;
   logic [3:0] rx_ev = 4'h0, rx_rd = 4'h0;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
   logic host_irq, evt_irq, rd_q = 1'h0;
   int num_errors = 0, checked = 0, cycles = 0, rises = 0, host_edges;
   int ctl, pend, al, lost, ms, irq_exp, exp_q[$];
   int ev, em, lev, alq, clq, evirq;

   always #2 clk_sys = ~clk_sys;

   hif_top DUT (.clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .round_robin_forward_mode(rr_mode),
      .aligned_forward_mode(al_mode), .fwd_engine_aligned(eng),
      .fwd_frame_sent(frame), .fwd_align_loss(loss),
      .tx_port_event(tx_ev), .tx_port_event_status_rd(tx_rd),
      .rx_port_event(rx_ev), .rx_port_cause_rd(rx_rd),
      .host_irq(host_irq), .evt_irq(evt_irq));
   hif_host_model u_host (.clk_sys(clk_sys), .rstn(rstn),
      .host_irq(host_irq), .irq_edges(host_edges));

   function automatic int img_of(logic [7:0] a);
      case (a)
         8'h22: return lost * 4 + al;
         8'h23: return ctl;
         8'h24: return ((pend & ctl & 31) != 0) * 128 + pend;
         8'h30: return ev;
         8'h31: return em;
         default: return 0;
      endcase
   endfunction

   always @(posedge clk_sys or negedge rstn)
   begin
      int nxt;
      if (!rstn)
         {ctl, pend, al, lost, ms, irq_exp, ev, em, lev, alq, clq, evirq} = '0;
      else
      begin
         if (rd_q)
            `CHK("rdata", 8'(exp_q.pop_front()), reg_rdata)
         `CHK("host_irq", 1'(irq_exp), host_irq)
         `CHK("evt_irq", 1'(evirq), evt_irq)
         evirq = (ev & em) != 0;
         rd_q = reg_rd;
         if (reg_rd)
            exp_q.push_back(img_of(reg_addr));
         nxt = ctl[7] && (pend & ctl & 31) != 0;
         rises += nxt && !irq_exp;
         irq_exp = nxt;
         if (reg_wr && reg_addr == 8'h23)
            ctl = reg_wdata & 8'hbf;
         pend = (pend & ~{tx_rd, rx_rd}) | {tx_ev, rx_ev};
         if (reg_rd && reg_addr == 8'h22)
            lost = 0;
         // write one clears, a set in the same cycle wins
         if (reg_wr && reg_addr == 8'h30)
            ev = ev & ~reg_wdata;
         ev = ev | (al && !alq) * 4 | (rr_mode && al_mode && !clq) * 2 | lev;
         if (reg_wr && reg_addr == 8'h31)
            em = reg_wdata & 7;
         alq = al;
         clq = rr_mode && al_mode;
         lev = 0;
         if (!al_mode)
            ms = 0;
         else if (ms == 0)
            ms = 1;
         else if (frame)
            ms = 2;
         else if (loss && ms == 2)
         begin
            lost = 1;
            lev = 1;
            ms = 1;
         end
         al = al_mode && eng;
      end
   end

   task automatic report_and_stop();
      `CHK("irq rises", rises, host_edges)
      $display("checks %0d errors %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   always @(posedge clk_sys)
   begin
      cycles++;
      if (cycles == 2000)
      begin
         num_errors++;
         report_and_stop();
      end
   end

   // every strobe and pulse input is driven each cycle, so pulses end by themselves
   task automatic cyc(logic [1:0] w, logic [7:0] a, d, logic [4:0] s, c,
         logic [1:0] f);
      @(posedge clk_sys);
      {reg_wr, reg_rd} <= w;
      reg_addr <= a;
      reg_wdata <= d;
      {tx_ev, rx_ev} <= s;
      {tx_rd, rx_rd} <= c;
      {frame, loss} <= f;
   endtask
   task automatic idle(int n);
      repeat (n) cyc(0, 0, 0, 0, 0, 0);
   endtask
   task automatic rd(logic [7:0] a);
      cyc(1, a, 0, 0, 0, 0);
   endtask
   task automatic wr(logic [7:0] a, d);
      cyc(2, a, d, 0, 0, 0);
   endtask

   initial
   begin
      void'($urandom(66049));
      repeat (12) @(posedge clk_sys);
      rstn <= 1'h1;
      for (int i = 0; i < 4; i++)
         rd(8'h22 + i[7:0]);
      wr(8'h22, 8'hff);
      wr(8'h24, 8'hff);
      wr(8'h40, 8'hff);
      rd(8'h24);
      rd(8'h40);
      idle(2);
      $display("test reset done");
      wr(8'h23, 8'h01);
      cyc(0, 0, 0, 5'h01, 0, 0);
      idle(2);
      rd(8'h24);
      wr(8'h23, 8'hff);
      cyc(0, 0, 0, 5'h10, 0, 0);
      idle(3);
      cyc(0, 0, 0, 5'h01, 5'h01, 0);
      idle(2);
      cyc(0, 0, 0, 0, 5'h11, 0);
      idle(3);
      wr(8'h23, 8'h80);
      cyc(0, 0, 0, 5'h0e, 0, 0);
      rd(8'h24);
      cyc(0, 0, 0, 0, 5'h1f, 0);
      idle(2);
      $display("test irq done");
      al_mode <= 1'h1;
      eng <= 1'h1;
      idle(3);
      cyc(0, 0, 0, 0, 0, 2'h1);
      rd(8'h22);
      cyc(0, 0, 0, 0, 0, 2'h2);
      idle(2);
      cyc(0, 0, 0, 0, 0, 2'h1);
      cyc(0, 0, 0, 0, 0, 2'h2);
      idle(1);
      cyc(1, 8'h22, 0, 0, 0, 2'h1);
      rd(8'h22);
      rd(8'h22);
      al_mode <= 1'h0;
      idle(2);
      al_mode <= 1'h1;
      idle(2);
      cyc(0, 0, 0, 0, 0, 2'h1);
      rd(8'h22);
      al_mode <= 1'h0;
      rr_mode <= 1'h1;
      idle(2);
      rd(8'h22);
      rr_mode <= 1'h0;
      al_mode <= 1'h1;
      $display("test forward done");
      wr(8'h31, 8'h07);
      rr_mode <= 1'h1;
      idle(2);
      rr_mode <= 1'h0;
      rd(8'h30);
      wr(8'h30, 8'h07);
      rd(8'h30);
      rd(8'h31);
      idle(2);
      $display("test events done");
      repeat (400)
      begin
         logic [31:0] r;
         r = $urandom;
         eng <= r[31];
         if (r[3:0] == 4'h0)
            wr(8'h23, r[15:8]);
         else
            cyc({1'h0, r[4]}, 8'h22 + r[6:5], 0, r[11:7] & r[16:12],
               r[21:17] & r[26:22],
               r[30:27] == 4'h1 ? 2'h2 : {1'h0, r[30:27] == 4'h2});
      end
      idle(3);
      $display("test random done");
      report_and_stop();
   end
endmodule
